// ==== fwd_params.svh ====
// constants for the free running watchdog: offsets, fields, reset values, timing counts
// assumes a 125 MHz system clock and a one-cycle strobe per divided oscillator period
`ifndef FWD_PARAMS_SVH
`define FWD_PARAMS_SVH

// register byte offsets on the APB
`define FWD_CTRL_OFFSET 12'h000
`define FWD_STATUS_OFFSET 12'h004

// watchdog_control fields and reset value
`define FWD_ACT_BIT 7
`define FWD_TOP_BIT 6
`define FWD_CTRL_RESET 8'h7F
`define FWD_EXPIRE_VALUE 7'h40

// status fields
`define FWD_ST_ACTIVE_BIT 0
`define FWD_ST_PULSE_BIT 1
`define FWD_ST_HWOPT_BIT 2

// timebase: decrement every 16384 oscillator periods, split as div 64 then 256 stages
`define FWD_TICK_OSC 16384
`define FWD_DIV 64
`define FWD_STAGE_STEPS (`FWD_TICK_OSC / `FWD_DIV)
`define FWD_MIN_BASE_OFFSET 128

// per-timebase constants (msb / lsb) for codes 00, 01, 10, 11 (2, 4, 10, 25 ms)
`define FWD_MSB_TB0 4
`define FWD_MSB_TB1 8
`define FWD_MSB_TB2 20
`define FWD_MSB_TB3 49
`define FWD_LSB_TB0 59
`define FWD_LSB_TB1 53
`define FWD_LSB_TB2 35
`define FWD_LSB_TB3 54

// reset pulse length, rounded down to whole clock cycles
`define FWD_PULSE_NS 30000
`define FWD_CLK_MHZ 125
`define FWD_PULSE_CYCLES (`FWD_PULSE_NS * `FWD_CLK_MHZ / 1000)

`endif

// ==== fwd_pkg.sv ====
// types shared by the watchdog files
// assumes fwd_params.svh supplies the numeric constants
package fwd_pkg;
  typedef enum logic {st_idle, st_pulse} fwd_state_t;
  typedef logic [6:0] fwd_count_t;
endpackage : fwd_pkg

// ==== fwd_timebase.sv ====
// watchdog timebase prescaler: oscillator strobe -> one decrement tick per 16384 strobes
// assumes osc_tick is a one-cycle strobe synchronous to clk
`timescale 1ns/1ns
`include "fwd_params.svh"
module fwd_timebase (
  // system
  input wire logic clk,
  input wire logic rst,
  // timebase
  input wire logic osc_tick,
  input wire logic [1:0] timebase_select,
  input wire logic ctrl_write,
  // tick out
  output logic wdg_tick
);

  function automatic logic [8:0] lsb_of(input logic [1:0] sel);
    logic [8:0] v;
    v = 9'(`FWD_LSB_TB0);
    case (sel)
      2'h1: v = 9'(`FWD_LSB_TB1);
      2'h2: v = 9'(`FWD_LSB_TB2);
      2'h3: v = 9'(`FWD_LSB_TB3);
      default: v = 9'(`FWD_LSB_TB0);
    endcase
    return v;
  endfunction : lsb_of

  logic [5:0] div_r;
  logic [7:0] stage_r;
  logic skip_r;
  logic tick_r;

  wire div_wrap = osc_tick && (div_r == 6'(`FWD_DIV - 1));
  wire stage_wrap = div_wrap && (stage_r == 8'(`FWD_STAGE_STEPS - 1));
  wire [8:0] remaining = 9'(`FWD_STAGE_STEPS) - {1'b0, stage_r};
  wire [8:0] min_first = lsb_of(timebase_select) + 9'(`FWD_MIN_BASE_OFFSET);
  // a write too close to the next stage wrap drops that tick
  wire too_close = ctrl_write && (remaining <= min_first); // R14 R15

  // prescaler runs freely and a write never restarts it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 6'h00;
      stage_r <= 8'h00;
    end
    else if (osc_tick) // R09
    begin
      div_r <= div_r + 6'h01;
      if (div_wrap)
        stage_r <= stage_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      skip_r <= 1'b0;
    else if (stage_wrap)
      skip_r <= 1'b0;
    else if (too_close) // R14
      skip_r <= 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_r <= 1'b0;
    else
      tick_r <= stage_wrap && !skip_r && !too_close; // R01 R14
  end

  assign wdg_tick = tick_r;

endmodule : fwd_timebase

// ==== fwd_watchdog.sv ====
// free running watchdog: control register on APB, 7-bit down counter, reset pulse
// assumes APB master in the clk domain and synchronous option and halt inputs
//
// Notes on behaviour
// R01: counter decrements once every 16384 divided oscillator periods, approximately.
// R02: lower six counter bits give 64 programmable timeout steps.
// R03: active watchdog rolling counter from 40h to 3Fh starts a reset.
// R04: reset pin pulled low about 30 microseconds for a watchdog reset.
// R05: software rewrites the control register regularly before expiry.
// R06: counter keeps decrementing even while the watchdog is inactive.
// R07: software writes only FFh down to C0h.
// R08: lower six bits are the steps remaining before reset.
// R09: control writes never restart the prescaler, so timeout has min and max.
// R10: watchdog off after any reset; once on, software cannot disable it.
// R11: write with activation set and top bit clear resets at once.
// R12: halt while active with halt-reset option set causes a reset.
// R13: option input selects the hardware watchdog variant.
// R14: minimum base timeout is (lsb plus 128) times 64 oscillator periods.
// R15: timebase codes 00..11 pick constant pairs 4/59, 8/53, 20/35, 49/54.
// R16: software may set the activation bit; only a reset clears it.
// R17: hardware option keeps the watchdog always active, activation bit ignored.
// R18: a write loads all seven counter bits; counting resumes from there.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "fwd_params.svh"
module fwd_watchdog (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timebase and options
  input wire logic osc_tick,
  input wire logic [1:0] timebase_select,
  input wire logic hw_watchdog_opt,
  input wire logic halt_reset_option,
  input wire logic halt_exec,
  // reset pin, open drain
  output logic reset_pin_out,
  output logic reset_pin_oe
);

  localparam int PULSE_LAST = `FWD_PULSE_CYCLES - 1;

  fwd_pkg::fwd_state_t state_r;
  fwd_pkg::fwd_state_t state_nxt;
  fwd_pkg::fwd_count_t count_r;
  fwd_pkg::fwd_count_t count_nxt;
  logic act_r;
  logic act_nxt;
  logic [11:0] pulse_cnt_r;
  logic [11:0] pulse_cnt_nxt;
  logic oe_r;
  logic [31:0] prdata_r;
  logic wdg_tick;

  // bus decode
  wire setup_rd = psel && !penable && !pwrite;
  wire access = psel && penable;
  wire hit_ctrl = (paddr == `FWD_CTRL_OFFSET);
  wire hit_status = (paddr == `FWD_STATUS_OFFSET);
  wire mapped = hit_ctrl || hit_status;
  wire wr_ctrl = access && pwrite && hit_ctrl;

  fwd_timebase u_timebase (
    .clk(clk),
    .rst(rst),
    .osc_tick(osc_tick),
    .timebase_select(timebase_select),
    .ctrl_write(wr_ctrl),
    .wdg_tick(wdg_tick)
  );

  // activation and triggers
  wire eff_active = act_r || hw_watchdog_opt; // R13 R17
  wire wr_act = pwdata[`FWD_ACT_BIT] || act_r || hw_watchdog_opt;
  wire idle = (state_r == fwd_pkg::st_idle);
  wire pulse_end = (state_r == fwd_pkg::st_pulse) && (pulse_cnt_r == 12'(PULSE_LAST));
  wire expire = wdg_tick && !wr_ctrl && (count_r == `FWD_EXPIRE_VALUE) && eff_active; // R03
  wire sw_reset = wr_ctrl && wr_act && !pwdata[`FWD_TOP_BIT]; // R11
  wire halt_reset = halt_exec && eff_active && halt_reset_option; // R12
  wire trigger = idle && (expire || sw_reset || halt_reset);

  wire [7:0] ctrl_view = {act_r, count_r};
  wire [2:0] status_view = {hw_watchdog_opt, !idle, eff_active};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_view} :
                       hit_status ? {29'h00000000, status_view} : 32'h00000000;

  // counter and activation next state
  always_comb
  begin
    count_nxt = count_r;
    act_nxt = act_r;
    if (pulse_end)
    begin
      count_nxt = 7'(`FWD_CTRL_RESET); // R10 R16
      act_nxt = 1'b0;
    end
    else if (wr_ctrl)
    begin
      count_nxt = pwdata[6:0]; // R18 R02 R08
      act_nxt = act_r || pwdata[`FWD_ACT_BIT]; // R10 R16
    end
    else if (wdg_tick)
      count_nxt = count_r - 7'h01; // R01 R06
  end

  // reset pulse sequencer
  always_comb
  begin
    state_nxt = state_r;
    pulse_cnt_nxt = pulse_cnt_r;
    case (state_r)
      fwd_pkg::st_idle:
      begin
        pulse_cnt_nxt = 12'h000;
        if (trigger)
          state_nxt = fwd_pkg::st_pulse;
      end
      fwd_pkg::st_pulse:
      begin
        pulse_cnt_nxt = pulse_cnt_r + 12'h001; // R04
        if (pulse_end)
        begin
          state_nxt = fwd_pkg::st_idle;
          pulse_cnt_nxt = 12'h000;
        end
      end
      default:
        state_nxt = fwd_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= 7'(`FWD_CTRL_RESET);
      act_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      act_r <= act_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= fwd_pkg::st_idle;
      pulse_cnt_r <= 12'h000;
      oe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      oe_r <= (state_nxt == fwd_pkg::st_pulse); // R04
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_r <= 32'h00000000;
    else if (setup_rd)
      prdata_r <= rd_mux;
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = oe_r;

  chk_expire_reset: assert property ( // R03
    @(posedge clk) disable iff (rst)
    expire && idle |=> reset_pin_oe
  ) else $error("expiry at 40h did not start reset pulse");

  chk_pulse_len: assert property ( // R04
    @(posedge clk) disable iff (rst)
    $fell(reset_pin_oe) |-> $past(pulse_cnt_r) == 12'(PULSE_LAST)
  ) else $error("reset pulse length wrong");

  chk_pulse_hold: assert property ( // R04
    @(posedge clk) disable iff (rst)
    $rose(reset_pin_oe) |-> reset_pin_oe [*8]
  ) else $error("reset pulse ended too early");

  chk_count_dec: assert property ( // R01 R06
    @(posedge clk) disable iff (rst)
    wdg_tick && !wr_ctrl && !pulse_end |=> count_r == $past(count_r) - 7'h01
  ) else $error("counter did not decrement on tick");

  chk_count_hold: assert property ( // R01
    @(posedge clk) disable iff (rst)
    !wdg_tick && !wr_ctrl && !pulse_end |=> $stable(count_r)
  ) else $error("counter moved without tick");

  chk_write_load: assert property ( // R18
    @(posedge clk) disable iff (rst)
    wr_ctrl && !pulse_end |=> count_r == $past(pwdata[6:0])
  ) else $error("write did not load counter");

  chk_act_sticky: assert property ( // R10
    @(posedge clk) disable iff (rst)
    act_r && !pulse_end |=> act_r
  ) else $error("activation bit cleared by software");

  chk_act_cleared: assert property ( // R16
    @(posedge clk) disable iff (rst)
    pulse_end |=> !act_r && count_r == 7'(`FWD_CTRL_RESET)
  ) else $error("reset did not clear activation");

  chk_sw_reset: assert property ( // R11
    @(posedge clk) disable iff (rst)
    wr_ctrl && pwdata[7] && !pwdata[6] && idle |=> reset_pin_oe
  ) else $error("software reset write ignored");

  chk_halt_reset: assert property ( // R12
    @(posedge clk) disable iff (rst)
    halt_exec && halt_reset_option && eff_active && idle |=> reset_pin_oe
  ) else $error("halt reset not generated");

  chk_hw_option: assert property ( // R17
    @(posedge clk) disable iff (rst)
    hw_watchdog_opt && wdg_tick && !wr_ctrl && count_r == 7'h40 && idle |=> reset_pin_oe
  ) else $error("hardware watchdog did not reset");

  chk_no_spurious: assert property ( // R10
    @(posedge clk) disable iff (rst)
    idle && !trigger |=> !reset_pin_oe
  ) else $error("reset pulse without cause");

  chk_rd_ctrl: assert property ( // R02 R08
    @(posedge clk) disable iff (rst)
    setup_rd && hit_ctrl |=> prdata == {24'h000000, $past(act_r), $past(count_r)}
  ) else $error("control read data wrong");

  chk_rd_hwopt: assert property ( // R13
    @(posedge clk) disable iff (rst)
    setup_rd && hit_status |=> prdata[`FWD_ST_HWOPT_BIT] == $past(hw_watchdog_opt)
  ) else $error("status hardware option bit wrong");

  chk_hw_active: assert property ( // R17
    @(posedge clk) disable iff (rst)
    setup_rd && hit_status && hw_watchdog_opt |=> prdata[`FWD_ST_ACTIVE_BIT]
  ) else $error("hardware option not shown active");

  chk_rd_pulse: assert property ( // R04
    @(posedge clk) disable iff (rst)
    setup_rd && hit_status |=> prdata[`FWD_ST_PULSE_BIT] == $past(reset_pin_oe)
  ) else $error("status pulse bit wrong");

  chk_oe_state: assert property ( // R04
    @(posedge clk) disable iff (rst)
    reset_pin_oe == !idle
  ) else $error("reset pin enable out of step with pulse");

  chk_pulse_count: assert property ( // R04
    @(posedge clk) disable iff (rst)
    !idle && !pulse_end |=> !idle && pulse_cnt_r == $past(pulse_cnt_r) + 12'h001
  ) else $error("reset pulse restarted or stalled");

  chk_idle_dec: assert property ( // R06
    @(posedge clk) disable iff (rst)
    wdg_tick && !wr_ctrl && !pulse_end && !eff_active |=> count_r == $past(count_r) - 7'h01
  ) else $error("inactive counter stopped");

  chk_inactive_quiet: assert property ( // R03 R10
    @(posedge clk) disable iff (rst)
    wdg_tick && count_r == `FWD_EXPIRE_VALUE && !eff_active && !wr_ctrl && idle |=> !reset_pin_oe
  ) else $error("inactive watchdog reset on expiry");

  chk_write_sets_act: assert property ( // R16
    @(posedge clk) disable iff (rst)
    wr_ctrl && pwdata[`FWD_ACT_BIT] && !pulse_end |=> act_r
  ) else $error("activation bit not set by write");

  chk_tick_single: assert property ( // R01
    @(posedge clk) disable iff (rst)
    wdg_tick |=> !wdg_tick
  ) else $error("decrement tick longer than one cycle");

  chk_expire_step: assert property ( // R03
    @(posedge clk) disable iff (rst)
    expire && !pulse_end |=> count_r == 7'h3F
  ) else $error("expiry did not roll to 3Fh");

  chk_hw_sw_reset: assert property ( // R17
    @(posedge clk) disable iff (rst)
    wr_ctrl && hw_watchdog_opt && !pwdata[`FWD_TOP_BIT] && idle |=> reset_pin_oe
  ) else $error("hardware option write with top bit clear ignored");

  chk_halt_inactive: assert property ( // R12
    @(posedge clk) disable iff (rst)
    halt_exec && !eff_active && !wr_ctrl && idle |=> !reset_pin_oe
  ) else $error("halt reset while watchdog inactive");

endmodule : fwd_watchdog

// ==== fwd_watchdog_bench.sv ====
// self-checking bench for the free running watchdog
// assumes fwd_params.svh and the fwd_watchdog top module; osc_tick strobes every cycle
`timescale 1ns/1ns
`include "fwd_params.svh"
module fwd_watchdog_bench;
  logic clk, rst, psel, penable, pwrite, osc_tick, hw_watchdog_opt, halt_reset_option, halt_exec;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [1:0] timebase_select;
  logic pready, pslverr, reset_pin_out, reset_pin_oe;
  int error_cnt = 0;
  int check_count = 0;
  int plen = 0;
  logic [33:0] exp_q[$];
  int pulse_q[$];
  logic [33:0] e;

  fwd_watchdog uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
    .timebase_select(timebase_select), .hw_watchdog_opt(hw_watchdog_opt),
    .halt_reset_option(halt_reset_option), .halt_exec(halt_exec),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe)
  );

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task fail;
    error_cnt++;
    $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    finish_test();
  endtask : fail

  // one apb transfer; the expected reply is queued for the monitor
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err, input logic [31:0] x);
    int n;
    exp_q.push_back({~w, err, x});
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      fail();
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  task halt_pulse;
    halt_exec <= 1;
    @(posedge clk);
    halt_exec <= 0;
  endtask : halt_pulse

  // waits for a whole reset pulse, its length is judged by the monitor
  task wait_pulse(input int bound);
    int n;
    pulse_q.push_back(`FWD_PULSE_CYCLES);
    n = 0;
    while (reset_pin_oe !== 1'b1 && n < bound)
    begin
      @(posedge clk);
      n++;
    end
    if (reset_pin_oe !== 1'b1)
      fail();
    n = 0;
    while (reset_pin_oe !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (reset_pin_oe !== 1'b0)
      fail();
    @(posedge clk);
  endtask : wait_pulse

  // monitor: replies and reset pulses against the oldest note
  always @(posedge clk)
  begin
    if (psel && penable && pready)
    begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33])
        chk(prdata, e[31:0]);
    end
    if (reset_pin_oe === 1'b1)
      plen++;
    else if (plen != 0)
    begin
      if (pulse_q.size() > 0)
        chk(plen, pulse_q.pop_front());
      else
        chk(plen, 32'h0);
      chk({31'h0, reset_pin_out}, 32'h0);
      plen = 0;
    end
  end

  initial
  begin
    rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    osc_tick = 1;
    timebase_select = 2'h0;
    hw_watchdog_opt = 0;
    halt_reset_option = 0;
    halt_exec = 0;
    rnd = $urandom(32'hC8A9A31B);
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, `FWD_CTRL_OFFSET, 32'h0, 0, 32'h7F);
    apb(0, `FWD_STATUS_OFFSET, 32'h0, 0, 32'h0);
    apb(1, 12'h008, 32'hFF, 1, 32'h0);
    apb(0, 12'h008, 32'h0, 1, 32'h0);
    repeat (16480) @(posedge clk);
    apb(0, `FWD_CTRL_OFFSET, 32'h0, 0, 32'h7E);
    // halt while inactive: any pulse here finds no note and is flagged
    halt_reset_option <= 1;
    halt_pulse();
    for (int t = 0; t < 4; t++)
    begin
      rnd = $urandom;
      timebase_select <= t[1:0];
      apb(1, `FWD_CTRL_OFFSET, {24'h0, 2'b11, rnd[5:0]}, 0, 32'h0);
      apb(0, `FWD_CTRL_OFFSET, 32'h0, 0, {24'h0, 2'b11, rnd[5:0]});
      apb(1, `FWD_CTRL_OFFSET, {24'h0, 2'b01, rnd[5:0]}, 0, 32'h0);
      apb(1, `FWD_STATUS_OFFSET, 32'h0, 0, 32'h0);
      apb(0, `FWD_STATUS_OFFSET, 32'h0, 0, 32'h1);
      halt_pulse();
      wait_pulse(10);
      apb(0, `FWD_STATUS_OFFSET, 32'h0, 0, 32'h0);
      apb(0, `FWD_CTRL_OFFSET, 32'h0, 0, 32'h7F);
    end
    apb(1, `FWD_CTRL_OFFSET, 32'h80, 0, 32'h0);
    wait_pulse(10);
    apb(1, `FWD_CTRL_OFFSET, 32'hC0, 0, 32'h0);
    wait_pulse(50000);
    hw_watchdog_opt <= 1;
    apb(0, `FWD_STATUS_OFFSET, 32'h0, 0, 32'h5);
    apb(1, `FWD_CTRL_OFFSET, 32'h3F, 0, 32'h0);
    wait_pulse(10);
    apb(0, `FWD_STATUS_OFFSET, 32'h0, 0, 32'h5);
    // hardware option: expiry resets with the activation bit left clear
    apb(1, `FWD_CTRL_OFFSET, 32'h40, 0, 32'h0);
    wait_pulse(40000);
    apb(0, `FWD_CTRL_OFFSET, 32'h0, 0, 32'h7F);
    finish_test();
  end
endmodule : fwd_watchdog_bench
